// ===== ucd_pkg.sv
// shared constants of the uart command decoder
package ucd_pkg;
    // apb map: the command register index is not word aligned, so its byte
    // address is four times the index
    localparam int unsigned CMD_IDX = 32'h0000_0012; // command reg index
    localparam int unsigned CMD_ADDR = CMD_IDX * 4; // command reg byte addr
    localparam int unsigned SR_ADDR = 32'h0000_0004; // channel status
    localparam int unsigned ISR_ADDR = 32'h0000_0008; // interrupt status
    localparam int unsigned CTL_ADDR = 32'h0000_000C; // control state

    // command codes in bits 4:0 of the command byte
    localparam logic [4:0] CMD_NOP = 5'h00; // no command
    localparam logic [4:0] CMD_RSVD = 5'h01; // reserved, acts as no command
    localparam logic [4:0] CMD_RX_RST = 5'h02; // reset receiver
    localparam logic [4:0] CMD_TX_RST = 5'h03; // reset transmitter
    localparam logic [4:0] CMD_ERR_CLR = 5'h04; // reset error status
    localparam logic [4:0] CMD_BCHG_CLR = 5'h05; // reset break change flag
    localparam logic [4:0] CMD_BRK_ON = 5'h06; // start break
    localparam logic [4:0] CMD_BRK_OFF = 5'h07; // stop break
    localparam logic [4:0] CMD_RTS_ON = 5'h08; // assert request to send
    localparam logic [4:0] CMD_RTS_OFF = 5'h09; // negate request to send

    // field positions of the command byte
    localparam int unsigned CODE_MSB = 4; // top bit of the command code
    localparam int unsigned LOCK_BIT = 7; // 1 = enables may change
    localparam int unsigned TXEN_BIT = 6; // transmitter enable
    localparam int unsigned RXEN_BIT = 5; // receiver enable

    // status layouts
    localparam int unsigned SR_ERR_LSB = 4; // error flags sit in bits 7:4
    localparam int unsigned ISR_BCHG_BIT = 2; // break change flag
    localparam int unsigned CTL_RXEN_BIT = 0; // receiver enabled
    localparam int unsigned CTL_TXEN_BIT = 1; // transmitter enabled
    localparam int unsigned CTL_RTS_BIT = 2; // request to send asserted
    localparam int unsigned CTL_BRK_BIT = 3; // break holds the line low
    localparam int unsigned CTL_PEND_BIT = 4; // break waits for idle
    localparam int unsigned CTL_RUN_BIT = 5; // transmitter still running

    // reset values
    localparam logic RXEN_RST = 1'b0; // receiver off after reset
    localparam logic TXEN_RST = 1'b0; // transmitter off after reset
    localparam logic RTS_LOW_RST = 1'b1; // request to send negated (high)
    localparam logic [3:0] ERR_RST = 4'h0; // no errors after reset
    localparam logic [31:0] RD_ZERO = 32'h0000_0000; // idle read data
endpackage : ucd_pkg

// ===== ucd_brk_if.sv
// link between the command decoder and its break sequencer
`timescale 1ns/1ps
interface ucd_brk_if (
    input wire logic clk, // device clock
    input wire logic rst_n // asynchronous reset, active low
);
    logic start; // start break command pulse
    logic stop; // stop break command pulse
    logic abort; // transmitter reset pulse
    logic tx_en; // transmitter enable level
    logic tx_idle; // transmitter idle, queue empty
    logic bit_tick; // one pulse per bit time
    logic brk_low; // line forced low
    logic hold_tx; // transmitter must not start a character
    logic pending; // break waits for the transmitter

    modport ctrl (input clk, rst_n, brk_low, hold_tx, pending,
        output start, stop, abort, tx_en, tx_idle, bit_tick);
    modport seq (input clk, rst_n, start, stop, abort, tx_en, tx_idle,
        bit_tick, output brk_low, hold_tx, pending);
endinterface : ucd_brk_if

// ===== ucd_break_seq.sv
// break sequencer: waits for idle, holds the line low, then a mark bit
`timescale 1ns/1ps
module ucd_break_seq (
    ucd_brk_if.seq b // sequencer side of the break link
);
    typedef enum logic [2:0] {
        BRK_IDLE, BRK_WAIT, BRK_LOW, BRK_END, BRK_MARK
    } ucd_brk_e;

    ucd_brk_e st_q; // current phase
    ucd_brk_e st_d; // next phase

    // next phase; a transmitter reset drops everything at once
    always_comb begin
        st_d = st_q;
        case (st_q)
            BRK_IDLE: begin
                // no break unless the transmitter is on
                if (b.start && b.tx_en && !b.abort) begin
                    st_d = BRK_WAIT;
                end
            end
            BRK_WAIT: begin
                // queued and later characters go first, then go low
                if (b.abort || b.stop || !b.tx_en) begin
                    st_d = BRK_IDLE;
                end else if (b.tx_idle) begin
                    st_d = BRK_LOW;
                end
            end
            BRK_LOW: begin
                if (b.abort) begin
                    st_d = BRK_IDLE;
                end else if (b.stop) begin
                    st_d = BRK_END;
                end
            end
            BRK_END: begin
                // release aligned to a bit edge, at most one bit later
                if (b.abort) begin
                    st_d = BRK_IDLE;
                end else if (b.bit_tick) begin
                    st_d = BRK_MARK;
                end
            end
            BRK_MARK: begin
                // one whole bit of mark before the next character
                if (b.abort || b.bit_tick) begin
                    st_d = BRK_IDLE;
                end
            end
            default: st_d = BRK_IDLE;
        endcase
    end

    // phase register
    always_ff @(posedge b.clk or negedge b.rst_n) begin
        if (!b.rst_n) begin
            st_q <= BRK_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign b.brk_low = (st_q == BRK_LOW) || (st_q == BRK_END);
    assign b.hold_tx = b.brk_low || (st_q == BRK_MARK);
    assign b.pending = (st_q == BRK_WAIT);

    default clocking cb @(posedge b.clk); endclocking
    default disable iff (!b.rst_n);

    sequence s_end_tick;
        (st_q == BRK_END) && b.bit_tick && !b.abort;
    endsequence

    sequence s_quiet_bits;
        (!b.bit_tick && !b.abort) [*3];
    endsequence

    a_break_gated_idle: assert property (
        $rose(b.brk_low) |-> $past(b.tx_idle) && $past(b.tx_en))
        else $error("break began while transmitter busy or disabled");
    a_break_needs_enable: assert property (
        (st_q == BRK_IDLE) && b.start && !b.tx_en |=> !b.pending)
        else $error("break accepted with transmitter disabled");
    a_stop_releases_line: assert property (
        s_end_tick |=> !b.brk_low)
        else $error("line not released at bit edge after stop");
    a_mark_bit_held: assert property (
        s_end_tick ##1 s_quiet_bits |-> b.hold_tx && !b.brk_low)
        else $error("mark bit after break cut short");
endmodule : ucd_break_seq

// ===== ucd_decoder.sv
// uart command decoder: apb command register, enables, flags and break
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Behaviour
// - decode one command; 00000 none, 00001 reserved
// - 00010 resets receiver like hardware reset
// - receiver reset empties the receive queue
// - 00011 resets transmitter like hardware reset
// - transmitter reset empties the transmit queue
// - 00100 clears the four error status flags
// - 00101 clears the break change flag
// - 00110 forces the serial output low
// - idle start may lag up to two bits
// - break follows the character being sent
// - break waits for queue drained and idle
// - break starts only with transmitter enabled
// - 00111 releases the line within two bits
// - one mark bit after break ends
// - 01000 drives request to send low
// - 01001 drives request to send high
// - lock bit zero keeps both enables unchanged; 00010 and 00011 still clear their enable with the lock bit zero
// - transmitter disable drains queue, then idles
// - receiver disable stops at once, keeps data
module ucd_decoder #(
    parameter int ADDR_W = 8 // apb address width
) (
    input wire logic core_clk, // device clock, 40 mhz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready, never waits
    output logic pslverr, // apb error on unmapped address
    input wire logic tx_idle, // transmitter idle and queue empty
    input wire logic tx_queue_room, // transmit queue has space
    input wire logic bit_tick, // one pulse per transmit bit time
    input wire logic [3:0] err_set, // break, framing, parity, overrun
    input wire logic brk_chg_set, // break detect change event
    output logic rx_reset, // receiver and queue reset pulse
    output logic tx_reset, // transmitter and queue reset pulse
    output logic rx_enable, // receiver enabled
    output logic tx_enable, // transmitter may run
    output logic transmit_space_flag, // transmitter ready for data
    output logic request_to_send_low, // request to send, active low
    output logic txd_break_low, // force serial output low
    output logic tx_hold, // keep the transmitter from starting
    output logic [3:0] err_status, // sticky error flags
    output logic brk_chg_flag // sticky break change flag
);
    // refuse an address bus too narrow for the command register
    if (ADDR_W < 8) begin : g_chk
        $error("ucd_decoder: ADDR_W must be at least 8");
    end

    // decoded apb traffic
    wire acc = psel && penable; // access phase edge takes effect
    wire rd_setup = psel && !penable && !pwrite; // latch read data
    wire hit_cmd = (paddr == ADDR_W'(ucd_pkg::CMD_ADDR));
    wire hit_sr = (paddr == ADDR_W'(ucd_pkg::SR_ADDR));
    wire hit_isr = (paddr == ADDR_W'(ucd_pkg::ISR_ADDR));
    wire hit_ctl = (paddr == ADDR_W'(ucd_pkg::CTL_ADDR));
    wire hit_any = hit_cmd || hit_sr || hit_isr || hit_ctl;
    wire cmd_wr = acc && pwrite && hit_cmd; // command byte arrives

    // command field split
    wire [4:0] code = pwdata[ucd_pkg::CODE_MSB:0];
    wire en_upd = cmd_wr && pwdata[ucd_pkg::LOCK_BIT];
    wire is_rx_rst = cmd_wr && (code == ucd_pkg::CMD_RX_RST);
    wire is_tx_rst = cmd_wr && (code == ucd_pkg::CMD_TX_RST);
    wire is_err_clr = cmd_wr && (code == ucd_pkg::CMD_ERR_CLR);
    wire is_bchg_clr = cmd_wr && (code == ucd_pkg::CMD_BCHG_CLR);
    wire is_brk_on = cmd_wr && (code == ucd_pkg::CMD_BRK_ON);
    wire is_brk_off = cmd_wr && (code == ucd_pkg::CMD_BRK_OFF);
    wire is_rts_on = cmd_wr && (code == ucd_pkg::CMD_RTS_ON);
    wire is_rts_off = cmd_wr && (code == ucd_pkg::CMD_RTS_OFF);
    // codes 00000, 00001 and 01010 upward decode to nothing here

    // state registers
    logic rx_en_q; // receiver enable
    logic rx_en_d;
    logic tx_en_q; // transmitter enable bit
    logic tx_en_d;
    logic tx_run_q; // transmitter running or draining
    logic tx_run_d;
    logic rts_low_q; // request to send pin level
    logic rts_low_d;
    logic [3:0] err_q; // sticky error flags, sr bits 7:4
    logic [3:0] err_d;
    logic bchg_q; // sticky break change flag
    logic bchg_d;
    logic rx_rst_q; // one cycle receiver reset
    logic tx_rst_q; // one cycle transmitter reset
    logic space_q; // transmitter ready for data
    logic [31:0] rdata_q; // read data held through the access phase
    logic [31:0] rdata_d;

    // enables: a reset command clears its side, an enable bit written in
    // the same command still wins so one write can reset and re-enable
    assign rx_en_d = en_upd ? pwdata[ucd_pkg::RXEN_BIT]
        : (is_rx_rst ? ucd_pkg::RXEN_RST : rx_en_q);
    assign tx_en_d = en_upd ? pwdata[ucd_pkg::TXEN_BIT]
        : (is_tx_rst ? ucd_pkg::TXEN_RST : tx_en_q);

    // a disabled transmitter keeps running until its queue has drained
    assign tx_run_d = !is_tx_rst
        && (tx_en_d || (tx_run_q && !tx_idle));

    // request to send follows the last of the two commands
    assign rts_low_d = is_rts_on ? 1'b0
        : (is_rts_off ? 1'b1 : rts_low_q);

    // sticky flags: a new event in the clearing cycle is kept
    assign err_d = (err_q & ~{4{is_err_clr}}) | err_set;
    assign bchg_d = (bchg_q & ~is_bchg_clr) | brk_chg_set;

    // break link
    ucd_brk_if brk (.clk(core_clk), .rst_n(rst_n));
    assign brk.start = is_brk_on;
    assign brk.stop = is_brk_off;
    assign brk.abort = is_tx_rst;
    assign brk.tx_en = tx_en_q;
    assign brk.tx_idle = tx_idle;
    assign brk.bit_tick = bit_tick;

    ucd_break_seq u_brk (
        .b(brk)
    );

    // read mux; the command register is write only and reads zero
    assign rdata_d = hit_sr ? {24'h00_0000, err_q, 4'h0}
        : hit_isr ? {29'h0000_0000, bchg_q, 2'h0}
        : hit_ctl ? {26'h000_0000, tx_run_q, brk.pending, brk.brk_low,
            !rts_low_q, tx_en_q, rx_en_q}
        : ucd_pkg::RD_ZERO;

    // enables and pin levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_en_q <= ucd_pkg::RXEN_RST;
            tx_en_q <= ucd_pkg::TXEN_RST;
            tx_run_q <= ucd_pkg::TXEN_RST;
            rts_low_q <= ucd_pkg::RTS_LOW_RST;
        end else begin
            rx_en_q <= rx_en_d;
            tx_en_q <= tx_en_d;
            tx_run_q <= tx_run_d;
            rts_low_q <= rts_low_d;
        end
    end

    // sticky status flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= ucd_pkg::ERR_RST;
            bchg_q <= 1'b0;
        end else begin
            err_q <= err_d;
            bchg_q <= bchg_d;
        end
    end

    // reset pulses; the datapath resets its queue pointers on them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_rst_q <= 1'b0;
            tx_rst_q <= 1'b0;
        end else begin
            rx_rst_q <= is_rx_rst;
            tx_rst_q <= is_tx_rst;
        end
    end

    // ready flag every cycle, read data capture in the setup cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            space_q <= 1'b0;
            rdata_q <= ucd_pkg::RD_ZERO;
        end else begin
            space_q <= tx_en_d && tx_queue_room;
            rdata_q <= rd_setup ? rdata_d : rdata_q;
        end
    end

    // apb answer: no wait states, error only on an unmapped address
    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;
    assign prdata = rdata_q;

    // outputs
    assign rx_reset = rx_rst_q;
    assign tx_reset = tx_rst_q;
    assign rx_enable = rx_en_q;
    assign tx_enable = tx_run_q;
    assign transmit_space_flag = space_q;
    assign request_to_send_low = rts_low_q;
    assign txd_break_low = brk.brk_low;
    assign tx_hold = brk.hold_tx;
    assign err_status = err_q;
    assign brk_chg_flag = bchg_q;

    // checks
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_quiet_cmd(logic [4:0] c);
        cmd_wr && (code == c) && !pwdata[ucd_pkg::LOCK_BIT];
    endsequence

    sequence s_no_effect;
        $stable(rx_en_q) && $stable(tx_en_q) && $stable(rts_low_q)
            && !rx_reset && !tx_reset;
    endsequence

    a_nop_no_effect: assert property (
        s_quiet_cmd(ucd_pkg::CMD_NOP) |=> s_no_effect)
        else $error("no command changed state");
    a_reserved_as_nop: assert property (
        s_quiet_cmd(ucd_pkg::CMD_RSVD) |=> s_no_effect)
        else $error("reserved code changed state");
    a_rx_reset_pulse: assert property (
        is_rx_rst && !en_upd |=> rx_reset && !rx_enable ##1 !rx_reset)
        else $error("receiver reset not a single pulse");
    a_tx_reset_pulse: assert property (
        is_tx_rst |=> tx_reset && !txd_break_low && !tx_hold)
        else $error("transmitter reset left break or no pulse");
    a_err_clear: assert property (
        is_err_clr && (err_set == 4'h0) |=> err_status == 4'h0)
        else $error("error flags not cleared");
    a_bchg_clear: assert property (
        is_bchg_clr && !brk_chg_set |=> !brk_chg_flag)
        else $error("break change flag not cleared");
    a_flag_set_wins: assert property (
        is_bchg_clr && brk_chg_set |=> brk_chg_flag)
        else $error("break change event lost during clear");
    a_rts_assert: assert property (
        is_rts_on |=> !request_to_send_low)
        else $error("request to send not driven low");
    a_rts_negate: assert property (
        is_rts_off |=> request_to_send_low)
        else $error("request to send not driven high");
    a_lock_keeps: assert property (
        cmd_wr && !pwdata[ucd_pkg::LOCK_BIT] && !is_rx_rst && !is_tx_rst
            |=> $stable(rx_enable) && $stable(tx_en_q))
        else $error("enables changed with lock bit zero");
    a_rx_off_now: assert property (
        en_upd && !pwdata[ucd_pkg::RXEN_BIT] && !is_err_clr |=> !rx_enable
            && (err_status == ($past(err_status) | $past(err_set))))
        else $error("receiver disable not immediate");
    a_tx_drains: assert property (
        tx_run_q && !tx_idle && !is_tx_rst |=> tx_enable)
        else $error("transmitter stopped before draining");
endmodule : ucd_decoder

// ===== ucd_tx_model.sv
// transmitter stand-in: character queue, bit timing and status events
`timescale 1ns/1ps
module ucd_tx_model #(
    parameter int BIT_CYC = 8 // clocks per bit time, short to keep runs brief
) (
    input wire logic core_clk, // device clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic tx_enable, // transmitter may run
    input wire logic tx_hold, // no new character may start
    input wire logic tx_reset, // empties queue and shifter
    input wire logic add_req, // bench queues one character
    input wire logic [3:0] err_req, // bench asks for error events
    input wire logic brk_req, // bench asks for a break change event
    output logic tx_idle, // shifter and queue both empty
    output logic tx_queue_room, // queue not full
    output logic bit_tick, // one pulse per bit time
    output logic [3:0] err_set, // error event pulses
    output logic brk_chg_set // break change event pulse
);
    int div_q; // bit time divider
    int queue_q; // characters waiting
    int bits_q; // bits left of the character on the line
    logic start_w; // a character leaves the queue
    logic add_w; // a character enters the queue
    assign tx_idle = (queue_q == 0) && (bits_q == 0);
    // only four places, so a full queue is reached quickly
    assign tx_queue_room = (queue_q < 4);
    assign bit_tick = (div_q == BIT_CYC - 1);
    // no start while the break or its mark bit holds the line
    assign start_w = bit_tick && bits_q == 0 && queue_q > 0 && tx_enable
        && !tx_hold;
    assign add_w = add_req && tx_queue_room;
    // queue and shifter; a reset pulse drops everything at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 0;
            queue_q <= 0;
            bits_q <= 0;
            err_set <= 4'h0;
            brk_chg_set <= 1'b0;
        end else begin
            div_q <= bit_tick ? 0 : div_q + 1;
            err_set <= err_req;
            brk_chg_set <= brk_req;
            if (tx_reset) begin
                queue_q <= 0;
                bits_q <= 0;
            end else begin
                queue_q <= queue_q + int'(add_w) - int'(start_w);
                if (start_w) begin
                    bits_q <= 10; // start, eight data, stop
                end else if (bit_tick && bits_q > 0) begin
                    bits_q <= bits_q - 1;
                end
            end
        end
    end
endmodule : ucd_tx_model

// ===== uart_command_decoder_test.sv
// self-checking bench for the uart command decoder
`timescale 1ns/1ps
module uart_command_decoder_test;
    localparam int BIT_CYC = 8; // clocks per bit time in the model
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr; // apb byte address
    logic [31:0] pwdata, prdata, rd; // apb data and last read word
    logic rd_err; // last read error flag
    logic tx_idle, tx_queue_room, bit_tick, brk_chg_set, add_req, brk_req;
    logic [3:0] err_set, err_req, err_status;
    logic rx_reset, tx_reset, rx_enable, tx_enable, transmit_space_flag;
    logic request_to_send_low, txd_break_low, tx_hold, brk_chg_flag;
    logic [9:0] snap; // outputs before a quiet command
    logic [4:0] quiet [4]; // codes that must change nothing
    int err_total, checks_done, n;
    logic [7:0] cmd_a; // command register byte address
    assign cmd_a = 8'(ucd_pkg::CMD_ADDR);

    ucd_decoder #(.ADDR_W(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_idle(tx_idle),
        .tx_queue_room(tx_queue_room), .bit_tick(bit_tick),
        .err_set(err_set), .brk_chg_set(brk_chg_set), .rx_reset(rx_reset),
        .tx_reset(tx_reset), .rx_enable(rx_enable), .tx_enable(tx_enable),
        .transmit_space_flag(transmit_space_flag),
        .request_to_send_low(request_to_send_low),
        .txd_break_low(txd_break_low), .tx_hold(tx_hold),
        .err_status(err_status), .brk_chg_flag(brk_chg_flag));
    ucd_tx_model #(.BIT_CYC(BIT_CYC)) i_tx (.core_clk(core_clk),
        .rst_n(rst_n), .tx_enable(tx_enable), .tx_hold(tx_hold),
        .tx_reset(tx_reset), .add_req(add_req), .err_req(err_req),
        .brk_req(brk_req), .tx_idle(tx_idle),
        .tx_queue_room(tx_queue_room), .bit_tick(bit_tick),
        .err_set(err_set), .brk_chg_set(brk_chg_set));

    // 25 ns period
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // compare and count; case inequality so unknowns never pass
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1; // let the committing edge land before anyone samples
    endtask : apb

    // command byte with the lock bit clear
    task automatic wrc(input logic [4:0] code);
        apb(1'b1, cmd_a, {27'h0, code});
    endtask : wrc

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
        input logic exp_err);
        apb(1'b0, a, 32'h0000_0000);
        chk("read_data", rd, exp);
        chk("read_err", rd_err, exp_err);
    endtask : rdchk

    // advance whole cycles, sampling just after the edge
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step

    // queue one character in the model
    task automatic add_char();
        @(posedge core_clk);
        add_req <= 1'b1;
        @(posedge core_clk);
        add_req <= 1'b0;
    endtask : add_char

    // wait, bounded, until the line is forced low
    task automatic wait_brk(input int lim);
        n = 0;
        while (txd_break_low !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_brk

    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // a hang is cut short well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end

    initial begin
        {rst_n, psel, penable, pwrite, add_req, brk_req} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_req = 4'h0;
        err_total = 0;
        checks_done = 0;
        quiet = '{ucd_pkg::CMD_NOP, ucd_pkg::CMD_RSVD, 5'h0A, 5'h1F};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        step(1);
        chk("reset_pins", {request_to_send_low, rx_enable, tx_enable,
            txd_break_low, tx_hold, err_status, brk_chg_flag}, 10'h200);
        rdchk(8'(ucd_pkg::CTL_ADDR), 32'h0000_0000, 1'b0);
        rdchk(cmd_a, 32'h0000_0000, 1'b0); // write-only place reads zero
        rdchk(8'h10, 32'h0000_0000, 1'b1); // unmapped place is refused
        // with no reset code, enables move only when the lock bit is set
        apb(1'b1, cmd_a, 32'h0000_0060);
        chk("lock_zero", {rx_enable, tx_enable}, 2'h0);
        apb(1'b1, cmd_a, 32'h0000_00E0);
        chk("lock_one", {rx_enable, tx_enable, transmit_space_flag},
            3'h7);
        wrc(ucd_pkg::CMD_RTS_ON);
        chk("rts_on", request_to_send_low, 1'b0);
        // sticky flags set by the far side, then cleared by command
        @(posedge core_clk);
        err_req <= 4'hF;
        brk_req <= 1'b1;
        @(posedge core_clk);
        err_req <= 4'h0;
        brk_req <= 1'b0;
        step(3);
        rdchk(8'(ucd_pkg::SR_ADDR), 32'h0000_00F0, 1'b0);
        rdchk(8'(ucd_pkg::ISR_ADDR), 32'h0000_0004, 1'b0);
        // quiet codes must leave enables, request to send, sticky flags and reset pulses alone
        foreach (quiet[i]) begin
            snap = {rx_enable, tx_enable, request_to_send_low, err_status,
                brk_chg_flag, rx_reset, tx_reset};
            wrc(quiet[i]);
            chk("quiet", {rx_enable, tx_enable, request_to_send_low,
                err_status, brk_chg_flag, rx_reset, tx_reset},
                snap);
        end
        wrc(ucd_pkg::CMD_ERR_CLR); // host clears after reading
        chk("err_clr", {err_status, brk_chg_flag}, 5'h01);
        // event and clear land in one cycle: the event must win
        fork
            wrc(ucd_pkg::CMD_BCHG_CLR);
            begin
                @(posedge core_clk);
                brk_req <= 1'b1;
                @(posedge core_clk);
                brk_req <= 1'b0;
            end
        join
        chk("bchg_keep", brk_chg_flag, 1'b1);
        wrc(ucd_pkg::CMD_BCHG_CLR);
        chk("bchg_clr", brk_chg_flag, 1'b0);
        wrc(ucd_pkg::CMD_RTS_OFF);
        chk("rts_off", request_to_send_low, 1'b1);
        wrc(ucd_pkg::CMD_RX_RST);
        chk("rx_rst", {rx_reset, rx_enable, tx_enable}, 3'h5);
        step(1);
        chk("rx_rst_end", rx_reset, 1'b0);
        // a break asked for while the transmitter is off never starts
        apb(1'b1, cmd_a, 32'h0000_0080);
        step(2);
        wrc(ucd_pkg::CMD_BRK_ON);
        step(2 * BIT_CYC);
        chk("brk_disabled", txd_break_low, 1'b0);
        // break behind queued characters waits for idle
        apb(1'b1, cmd_a, 32'h0000_00C0);
        add_char();
        add_char();
        step(2 * BIT_CYC);
        wrc(ucd_pkg::CMD_BRK_ON);
        n = 0;
        while (tx_idle !== 1'b1 && n < 1000) begin
            chk("brk_early", txd_break_low, 1'b0);
            step(1);
            n++;
        end
        wait_brk(2 * BIT_CYC);
        chk("brk_after_q", txd_break_low, 1'b1);
        wrc(ucd_pkg::CMD_BRK_OFF);
        n = 0;
        while (txd_break_low === 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        chk("brk_stop", n <= 2 * BIT_CYC, 1'b1);
        n = 0;
        while (tx_hold === 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        chk("mark_bit", 32'(n), 32'(BIT_CYC));
        // idle start, then a transmitter reset cuts the break short
        wrc(ucd_pkg::CMD_BRK_ON);
        wait_brk(2 * BIT_CYC);
        chk("brk_idle", txd_break_low, 1'b1);
        wrc(ucd_pkg::CMD_TX_RST);
        chk("tx_rst", {tx_reset, txd_break_low, tx_hold, tx_enable},
            4'h8);
        // disabling: receiver stops at once, transmitter drains first
        apb(1'b1, cmd_a, 32'h0000_00E0);
        add_char();
        step(2 * BIT_CYC);
        apb(1'b1, cmd_a, 32'h0000_0080);
        chk("disable", {rx_enable, tx_enable}, 2'h1);
        n = 0;
        while (tx_idle !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        step(1);
        chk("drained", {tx_enable, transmit_space_flag}, 2'h0);
        end_of_test();
    end
endmodule : uart_command_decoder_test
